// [verilog/avi_readback_defines.svh]
/*
  Register indices, field positions, code values and reset values of the
  auxiliary video information readback bank.
  Assumes inclusion by bare name; holds definitions only.
*/
`ifndef AVI_READBACK_DEFINES_SVH
`define AVI_READBACK_DEFINES_SVH

////////////////////////////////////////////////////////////////////////////////
// bus geometry
`define APB_AW           12
`define IDX_W            10
`define WORD_LSB         2
`define DATA_W           32

////////////////////////////////////////////////////////////////////////////////
// register indices; byte address is four times the index
`define IDX_SCALING      10'h083
`define IDX_VIC          10'h084
`define IDX_REPEAT       10'h085
`define IDX_BAR_LO       10'h086
`define IDX_FLAGS_A      10'h087
`define IDX_BAR_HI       10'h088
`define IDX_FLAGS_B      10'h08f
`define IDX_ASPECT       10'h0c0

////////////////////////////////////////////////////////////////////////////////
// field widths and positions
`define FLAG_W           7
`define SIG_W            40
`define KIND_W           3
`define STAT_AFD_OK_BIT  4
`define STAT_REP_RSV_BIT 5
`define STAT_BAR_BIT     6

////////////////////////////////////////////////////////////////////////////////
// code values
`define AFD_SAME         4'h8
`define AFD_CTR_4_3      4'h9
`define AFD_CTR_16_9     4'ha
`define AFD_CTR_14_9     4'hb
`define REPEAT_MAX       4'h9
`define BAR_NONE         16'h0000

////////////////////////////////////////////////////////////////////////////////
// reset values
`define RST_DATA         32'h0000_0000
`define RST_FLAGS        7'h00
`define RST_AFD          4'h0
`define RST_SCALING      2'h0
`define RST_VIC          7'h00
`define RST_REPEAT       4'h0
`define RST_BAR          16'h0000

`endif

// [verilog/avi_readback_pkg.sv]
/*
  Types shared by the readback bank and its change tracker.
  Assumes the defines header is compiled alongside.
*/
package avi_readback_pkg;

  // packet kind; value equals its change flag bit position
  typedef enum logic [2:0] {
    KIND_AVI   = 3'h0,
    KIND_AUDIO = 3'h1,
    KIND_SPD   = 3'h2,
    KIND_MPEG  = 3'h3,
    KIND_ACP   = 3'h4,
    KIND_ISRC1 = 3'h5,
    KIND_ISRC2 = 3'h6
  } packet_kind_t;

  typedef struct packed {
    logic [3:0]  aspect;
    logic [1:0]  scaling;
    logic [6:0]  video_format_id;
    logic [3:0]  repeat_count;
    logic [15:0] top_bar;
  } avi_fields_t;

endpackage

// [verilog/change_if.sv]
/*
  Carrier between the register bank and the packet change tracker.
  Assumes both ends run on the same clock.
*/
interface change_if;
  logic                          pkt_take;
  avi_readback_pkg::packet_kind_t pkt_kind;
  logic [39:0]                   pkt_sig;
  logic [6:0]                    changed;

  modport tracker (
    input  pkt_take,
    input  pkt_kind,
    input  pkt_sig,
    output changed
  );

  modport bank (
    output pkt_take,
    output pkt_kind,
    output pkt_sig,
    input  changed
  );
endinterface

// [verilog/packet_change_tracker.sv]
/*
  Keeps the last signature of each packet kind and pulses a change bit
  when a newly accepted packet differs from the stored one.
  Assumes packets are offered already validated, one per cycle at most.
*/
`include "avi_readback_defines.svh"

module packet_change_tracker (
  input  wire logic    ref_clk,
  input  wire logic    rst_b,
  change_if.tracker    chg
);

  localparam int KINDS = `FLAG_W;

  typedef struct packed {
    logic [KINDS-1:0][`SIG_W-1:0] sig;
    logic [KINDS-1:0]             seen;
    logic [KINDS-1:0]             changed;
  } trk_state_t;

  trk_state_t       s_reg;
  trk_state_t       s_next;
  logic [KINDS-1:0] hit;
  logic [KINDS-1:0] differs;

  ////////////////////////////////////////////////////////////////////////////
  genvar k;
  generate
    for (k = 0; k < KINDS; k++) begin : g_kind
      assign hit[k]     = chg.pkt_take && (chg.pkt_kind == `KIND_W'(k));
      // first packet after reset always counts as new content
      assign differs[k] = !s_reg.seen[k] || (s_reg.sig[k] != chg.pkt_sig);
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    s_next         = s_reg;
    s_next.changed = hit & differs;
    for (int i = 0; i < KINDS; i++) begin
      if (hit[i]) begin
        s_next.sig[i]  = chg.pkt_sig;
        s_next.seen[i] = 1'b1;
      end
    end
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  assign chg.changed = s_reg.changed;

endmodule

// [verilog/avi_infoframe_readback_regs.sv]
/*
  Read-only APB register bank exposing decoded auxiliary video information
  fields and a shared, clear-on-read packet change flag set.
  Assumes a packet decoder on ref_clk that offers one decoded packet per
  pulse of pkt_done, with pkt_good marking a complete, checked packet.
*/
// Our own choice: the APB slave port.
`include "avi_readback_defines.svh"

module avi_infoframe_readback_regs (
  input  wire logic                 ref_clk,
  input  wire logic                 rst_b,
  // apb slave
  input  wire logic                 psel,
  input  wire logic                 penable,
  input  wire logic                 pwrite,
  input  wire logic [`APB_AW-1:0]   paddr,
  input  wire logic [`DATA_W-1:0]   pwdata,
  output logic      [`DATA_W-1:0]   prdata,
  output logic                      pready,
  output logic                      pslverr,
  // decoder side, same clock
  input  wire logic                 pkt_done,
  input  wire logic                 pkt_good,
  input  wire logic [`KIND_W-1:0]   pkt_kind,
  input  wire logic [`SIG_W-1:0]    pkt_digest,
  input  wire logic [3:0]           avi_aspect,
  input  wire logic [1:0]           avi_scaling,
  input  wire logic [6:0]           avi_video_format_id,
  input  wire logic [3:0]           avi_repeat_count,
  input  wire logic [15:0]          avi_top_bar
);

  typedef struct packed {
    logic [`DATA_W-1:0]            prdata;
    logic                          pready;
    logic                          pslverr;
    avi_readback_pkg::avi_fields_t avi;
    logic [`FLAG_W-1:0]            change_flag;
  } bank_state_t;

  bank_state_t                    s_reg;
  bank_state_t                    s_next;
  avi_readback_pkg::avi_fields_t  avi_in;
  avi_readback_pkg::packet_kind_t kind_in;
  logic [`IDX_W-1:0]              idx;
  logic                           aligned;
  logic                           take_pkt;
  logic                           is_avi;
  logic                           access_wait;
  logic                           access_done;
  logic                           flag_addr;
  logic                           rd_hit;
  logic [`DATA_W-1:0]             rd_word;
  logic [`FLAG_W-1:0]             flag_clear;
  logic                           afd_known;
  logic                           repeat_reserved;
  logic                           bar_present;

  change_if chg ();

  ////////////////////////////////////////////////////////////////////////////
  // packet intake

  assign kind_in  = avi_readback_pkg::packet_kind_t'(pkt_kind);
  assign take_pkt = pkt_done && pkt_good;
  assign is_avi   = take_pkt && (kind_in == avi_readback_pkg::KIND_AVI);

  always_comb begin
    avi_in                 = '0;
    avi_in.aspect          = avi_aspect;
    avi_in.scaling         = avi_scaling;
    avi_in.video_format_id = avi_video_format_id;
    avi_in.repeat_count    = avi_repeat_count;
    avi_in.top_bar         = avi_top_bar;
  end

  // video information changes are judged on the fields actually stored,
  // other kinds on the digest the decoder supplies
  assign chg.pkt_take = take_pkt;
  assign chg.pkt_kind = kind_in;
  assign chg.pkt_sig  = is_avi ? `SIG_W'(avi_in) : pkt_digest;

  packet_change_tracker u_tracker (
    .ref_clk (ref_clk),
    .rst_b   (rst_b),
    .chg     (chg)
  );

  ////////////////////////////////////////////////////////////////////////////
  // derived status

  assign afd_known = (s_reg.avi.aspect == `AFD_SAME)     ||
                     (s_reg.avi.aspect == `AFD_CTR_4_3)  ||
                     (s_reg.avi.aspect == `AFD_CTR_16_9) ||
                     (s_reg.avi.aspect == `AFD_CTR_14_9);
  // reserved codes flagged so software never reads them as a count
  assign repeat_reserved = s_reg.avi.repeat_count > `REPEAT_MAX;
  assign bar_present     = s_reg.avi.top_bar != `BAR_NONE;

  ////////////////////////////////////////////////////////////////////////////
  // address decode and read mux

  assign idx       = paddr[`APB_AW-1:`WORD_LSB];
  assign aligned   = paddr[`WORD_LSB-1:0] == '0;
  assign flag_addr = aligned &&
                     ((idx == `IDX_FLAGS_A) || (idx == `IDX_FLAGS_B));

  always_comb begin
    rd_word = `RST_DATA;
    rd_hit  = aligned;
    if (flag_addr) begin
      rd_word[`FLAG_W-1:0] = s_reg.change_flag;
    end else begin
      unique case (idx)
        `IDX_SCALING: begin
          rd_word[1:0] = s_reg.avi.scaling;
        end
        `IDX_VIC: begin
          rd_word[6:0] = s_reg.avi.video_format_id;
        end
        `IDX_REPEAT: begin
          rd_word[3:0] = s_reg.avi.repeat_count;
        end
        `IDX_BAR_LO: begin
          rd_word[7:0] = s_reg.avi.top_bar[7:0];
        end
        `IDX_BAR_HI: begin
          rd_word[7:0] = s_reg.avi.top_bar[15:8];
        end
        `IDX_ASPECT: begin
          rd_word[3:0]                 = s_reg.avi.aspect;
          rd_word[`STAT_AFD_OK_BIT]    = afd_known;
          rd_word[`STAT_REP_RSV_BIT]   = repeat_reserved;
          rd_word[`STAT_BAR_BIT]       = bar_present;
        end
        default: begin
          rd_hit = 1'b0;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // apb handshake: one wait cycle, so read data and pready both leave
  // flip-flops; the snapshot is taken in the wait cycle

  assign access_wait = psel && penable && !s_reg.pready;
  assign access_done = psel && penable && s_reg.pready;

  // clear only the bits that were handed to software; a flag set after the
  // snapshot survives the clear instead of being lost
  always_comb begin
    flag_clear = '0;
    if (access_done && !pwrite && flag_addr && !s_reg.pslverr) begin
      flag_clear = s_reg.prdata[`FLAG_W-1:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // next state

  always_comb begin
    s_next         = s_reg;
    s_next.pready  = 1'b0;
    s_next.pslverr = 1'b0;
    if (access_wait) begin
      s_next.pready = 1'b1;
      // bank is read only: writes and holes answer with an error
      s_next.pslverr = pwrite || !rd_hit;
      s_next.prdata  = (pwrite || !rd_hit) ? `RST_DATA : rd_word;
    end
    if (is_avi) begin
      s_next.avi = avi_in;
    end
    // set wins over the read clear in the same cycle
    s_next.change_flag = (s_reg.change_flag & ~flag_clear) |
                         chg.changed;
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      s_reg.prdata               <= `RST_DATA;
      s_reg.pready               <= 1'b0;
      s_reg.pslverr              <= 1'b0;
      s_reg.avi.aspect           <= `RST_AFD;
      s_reg.avi.scaling          <= `RST_SCALING;
      s_reg.avi.video_format_id  <= `RST_VIC;
      s_reg.avi.repeat_count     <= `RST_REPEAT;
      s_reg.avi.top_bar          <= `RST_BAR;
      s_reg.change_flag          <= `RST_FLAGS;
    end else begin
      s_reg <= s_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs straight from flip-flops

  assign prdata  = s_reg.prdata;
  assign pready  = s_reg.pready;
  assign pslverr = s_reg.pslverr;

endmodule

// [sim/avi_readback_assertions.sv]
/*
  Port checker for the readback register bank, bound to its top module.
  Assumes the defines header is compiled alongside and one clock domain.
*/
`include "avi_readback_defines.svh"
module avi_readback_assertions (
  input wire logic               ref_clk,
  input wire logic               rst_b,
  input wire logic               psel,
  input wire logic               penable,
  input wire logic               pwrite,
  input wire logic [`APB_AW-1:0] paddr,
  input wire logic [`DATA_W-1:0] prdata,
  input wire logic               pready,
  input wire logic               pslverr
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!rst_b);

  ////////////////////////////////////////////////////////////////////////////
  sequence setup_s;
    psel && !penable;
  endsequence
  sequence wait_s;
    psel && penable && !pready;
  endsequence

  ////////////////////////////////////////////////////////////////////////////
  access_answer_a: assert property (setup_s ##1 wait_s |=> pready)
    else $error("no answer after one wait state");
  pready_pulse_a: assert property (pready |=> !pready)
    else $error("ready held longer than one cycle");
  idle_quiet_a: assert property (!psel |-> !pready && !pslverr)
    else $error("answer without a selected access");
  write_refused_a: assert property (pready && pwrite |-> pslverr)
    else $error("write not refused");
  error_data_a: assert property (pready && pslverr |-> prdata == 32'h0)
    else $error("refused access returned data");
  scaling_read_a: assert property (pready && !pwrite && paddr == 12'h20c |->
    !pslverr && prdata[31:2] == 30'h0) else $error("scaling read wrong");
  vic_width_a: assert property (pready && !pslverr && paddr == 12'h210 |->
    prdata[31:7] == 25'h0) else $error("format id upper bits set");
  repeat_width_a: assert property (pready && !pslverr && paddr == 12'h214 |->
    prdata[31:4] == 28'h0) else $error("repeat upper bits set");
  bar_byte_a: assert property (pready && !pslverr && (paddr == 12'h218 ||
    paddr == 12'h220) |-> prdata[31:8] == 24'h0) else $error("bar byte too wide");
  flag_width_a: assert property (pready && !pslverr && (paddr == 12'h21c ||
    paddr == 12'h23c) |-> prdata[31:7] == 25'h0) else $error("flag upper bits set");
  aspect_status_a: assert property (pready && !pslverr && paddr == 12'h300 |->
    prdata[4] == (prdata[3:2] == 2'b10)) else $error("aspect status bit wrong");
endmodule

bind avi_infoframe_readback_regs avi_readback_assertions chk_u (
  .ref_clk, .rst_b, .psel, .penable, .pwrite, .paddr, .prdata, .pready, .pslverr
);

// [sim/avi_infoframe_readback_regs_bench.sv]
/*
  Self-checking bench for the readback register bank over APB.
  Assumes the package, defines header and checker are compiled before it.
*/
module avi_infoframe_readback_regs_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic        ref_clk, rst_b, psel, penable, pwrite, pready, pslverr, e;
  logic        pkt_done, pkt_good;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, d;
  logic [2:0]  pkt_kind;
  logic [39:0] pkt_digest;
  int          n_fail, checks_done;
  avi_readback_pkg::avi_fields_t f, rows[5];
  logic [11:0] al[8] = '{12'h20c, 12'h210, 12'h214, 12'h218, 12'h21c, 12'h220,
                         12'h23c, 12'h300};

  avi_infoframe_readback_regs dut_u (
    .ref_clk, .rst_b, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .pkt_done, .pkt_good, .pkt_kind, .pkt_digest,
    .avi_aspect(f.aspect), .avi_scaling(f.scaling),
    .avi_video_format_id(f.video_format_id), .avi_repeat_count(f.repeat_count),
    .avi_top_bar(f.top_bar)
  );

  ////////////////////////////////////////////////////////////////////////////
  task test_done();
    if (n_fail == 0 && checks_done > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  task chk(input logic [31:0] g, input logic [31:0] x);
    checks_done++;
    if (g !== x) begin
      n_fail++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, g, x);
    end
  endtask
  // one idle cycle after each access so no signal is assigned twice at an edge
  task apb(input logic w, input logic [11:0] a);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= {20'h0, a};
    @(posedge ref_clk);
    penable <= 1'b1;
    // no cycle limit here: only the watchdog ends a hung access
    do begin
      @(posedge ref_clk);
    end while (pready !== 1'b1);
    d = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge ref_clk);
  endtask
  task rd(input logic [11:0] a, input logic [31:0] x);
    apb(1'b0, a);
    chk(d, x);
  endtask
  // flag lands one edge after the packet edge; three leave margin
  task pkt(input logic g, input logic [2:0] k, input logic [39:0] dg,
           input avi_readback_pkg::avi_fields_t r);
    pkt_done <= 1'b1;
    pkt_good <= g;
    pkt_kind <= k;
    pkt_digest <= dg;
    f <= r;
    @(posedge ref_clk);
    pkt_done <= 1'b0;
    repeat (3) @(posedge ref_clk);
  endtask
  function logic [31:0] st(input avi_readback_pkg::avi_fields_t r);
    return {25'h0, r.top_bar != 16'h0, r.repeat_count > 4'h9, r.aspect[3:2] == 2'b10,
            r.aspect};
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    ref_clk = 1'b0;
    forever #10 ref_clk = ~ref_clk;
  end
  initial begin
    repeat (5000) @(posedge ref_clk);
    n_fail++;
    test_done();
  end
  initial begin
    {rst_b, psel, penable, pwrite, pkt_done, pkt_good} = 6'h0;
    {paddr, pwdata, pkt_kind, pkt_digest, f} = '0;
    rows = '{'{4'h8, 2'h0, 7'h01, 4'h0, 16'h0000}, '{4'h9, 2'h1, 7'h10, 4'h9, 16'h0123},
             '{4'ha, 2'h2, 7'h7f, 4'ha, 16'hff00}, '{4'hb, 2'h3, 7'h22, 4'hf, 16'h0001},
             '{4'h3, 2'h1, 7'h05, 4'h1, 16'h8000}};
    repeat (4) @(posedge ref_clk);
    rst_b <= 1'b1;
    @(posedge ref_clk);
    foreach (al[i]) rd(al[i], 32'h0);
    foreach (rows[i]) begin
      pkt(1'b1, 3'h0, 40'h0, rows[i]);
      rd(12'h20c, {30'h0, rows[i].scaling});
      rd(12'h210, {25'h0, rows[i].video_format_id});
      rd(12'h214, {28'h0, rows[i].repeat_count});
      rd(12'h218, {24'h0, rows[i].top_bar[7:0]});
      rd(12'h220, {24'h0, rows[i].top_bar[15:8]});
      rd(12'h300, st(rows[i]));
      rd(i % 2 ? 12'h23c : 12'h21c, 32'h1);
      rd(i % 2 ? 12'h21c : 12'h23c, 32'h0);
    end
    pkt(1'b1, 3'h0, 40'h0, rows[4]);
    rd(12'h21c, 32'h0);
    pkt(1'b0, 3'h0, 40'h0, rows[0]);
    rd(12'h210, 32'h05);
    rd(12'h21c, 32'h0);
    for (int k = 1; k < 7; k++) begin
      pkt(1'b1, k[2:0], {37'h0, k[2:0]}, rows[4]);
      rd(k % 2 ? 12'h23c : 12'h21c, 32'h1 << k);
    end
    pkt(1'b1, 3'h7, 40'h9, rows[4]);
    pkt(1'b1, 3'h3, 40'h3, rows[4]);
    rd(12'h21c, 32'h0);
    pkt(1'b1, 3'h1, 40'ha, rows[4]);
    pkt(1'b1, 3'h2, 40'hb, rows[4]);
    rd(12'h23c, 32'h06);
    apb(1'b1, 12'h210);
    chk({31'h0, e}, 32'h1);
    rd(12'h210, 32'h05);
    apb(1'b0, 12'h224);
    chk({e, d[30:0]}, 32'h8000_0000);
    apb(1'b0, 12'h211);
    chk({31'h0, e}, 32'h1);
    // reserved repeat code, then a mid-run reset must empty fields and flags
    pkt(1'b1, 3'h0, 40'h0, rows[3]);
    rd(12'h300, 32'h7b);
    rst_b <= 1'b0;
    @(posedge ref_clk);
    rst_b <= 1'b1;
    @(posedge ref_clk);
    rd(12'h21c, 32'h0);
    rd(12'h300, 32'h0);
    test_done();
  end
endmodule
